//--- hw/port_flow_ctrl_pkg.sv
// Functional notes
// - Bit 6 enables half-duplex backpressure on port 1 when set.
// - Read-only bit 5 shows current duplex: 0 full, 1 half.
// - Read-only bit 4 shows whether receive pause handling is active now.
// - Read-only bit 3 shows whether transmit pause generation is active now.
// - Bit 2 enables received pause detection when manual or negotiation off.
// - Bit 1 enables pause frame generation when manual or negotiation off.
// - Bit 0 clear: negotiated result used, or bits 1-2 if negotiation off.
// - Bit 0 set: bits 1-2 decide full-duplex pause, ignoring negotiation.
// - Writable bits clear at reset, then take the per-port strap values on the first enabled clock after it.
// - A later strap reload from the loader updates the affected bits.
// - Default status bits follow several straps, not just one.
// - Writes never change the PHY pause advertisement for port 1.
// - Register sits at 1A0h, 32 bits, bits 31:7 reserved read zero.
package port_flow_ctrl_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] PORT1_FLOW_CTRL_OFS = 12'h01A0;
  localparam int BIT_BP = 6;
  localparam int BIT_DUP = 5;
  localparam int BIT_RX_ACT = 4;
  localparam int BIT_TX_ACT = 3;
  localparam int BIT_RX_EN = 2;
  localparam int BIT_TX_EN = 1;
  localparam int BIT_MANUAL = 0;
  localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0000_0000;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic sel;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic backpressure;
    logic pause;
    logic manual_sel;
    logic an_en;
    logic half_duplex;
  } strap_t;

  typedef struct packed {
    logic an_half_duplex;
    logic an_rx_pause;
    logic an_tx_pause;
  } an_result_t;

  typedef struct packed {
    logic backpressure_en;
    logic half_duplex;
    logic rx_pause_en;
    logic tx_pause_en;
  } mac_flow_t;

endpackage

//--- hw/pause_resolve.sv
`timescale 1ns/1ps
`default_nettype none
module pause_resolve
  import port_flow_ctrl_pkg::*;
(
  input wire logic manual_sel_i,
  input wire logic rx_en_i,
  input wire logic tx_en_i,
  input wire logic an_en_i,
  input wire logic half_i,
  input wire logic an_rx_i,
  input wire logic an_tx_i,
  output logic rx_act_o,
  output logic tx_act_o
);

  // ----------------------------------------
  // Source selection
  // ----------------------------------------
  wire logic use_bits;
  wire logic rx_sel;
  wire logic tx_sel;

  assign use_bits = manual_sel_i || !an_en_i;
  assign rx_sel = use_bits ? rx_en_i : an_rx_i;
  assign tx_sel = use_bits ? tx_en_i : an_tx_i;
  assign rx_act_o = rx_sel && !half_i;
  assign tx_act_o = tx_sel && !half_i;

endmodule // pause_resolve
`default_nettype wire

//--- hw/port_flow_control_select.sv
`timescale 1ns/1ps
`default_nettype none
module port_flow_control_select
  import port_flow_ctrl_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic clk_en_i,
  input wire reg_req_t reg_req_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire strap_t strap_i,
  input wire logic strap_load_i,
  input wire an_result_t an_result_i,
  output mac_flow_t mac_flow_o
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic strap_taken_reg;
  strap_t strap_reg;
  strap_t strap_next;
  logic bp_reg;
  logic bp_next;
  logic rx_en_reg;
  logic rx_en_next;
  logic tx_en_reg;
  logic tx_en_next;
  logic manual_reg;
  logic manual_next;
  logic half_reg;
  logic rx_act_reg;
  logic tx_act_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic rvalid_reg;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire logic hit;
  wire logic wr_hit;
  wire logic rd_req;
  wire logic take_strap;
  wire logic half_now;
  wire logic rx_act_now;
  wire logic tx_act_now;
  wire logic [DATA_W-1:0] reg_view;

  assign hit = reg_req_i.sel && (reg_req_i.addr == PORT1_FLOW_CTRL_OFS);
  assign wr_hit = hit && reg_req_i.wr;
  assign rd_req = reg_req_i.sel && !reg_req_i.wr;
  assign take_strap = !strap_taken_reg || strap_load_i;
  assign strap_next = take_strap ? strap_i : strap_reg;

  // Strap load takes priority over a write landing in the same cycle.
  assign bp_next = take_strap ? strap_i.backpressure
                 : wr_hit ? reg_req_i.wdata[BIT_BP] : bp_reg;
  assign rx_en_next = take_strap ? strap_i.pause
                    : wr_hit ? reg_req_i.wdata[BIT_RX_EN] : rx_en_reg;
  assign tx_en_next = take_strap ? strap_i.pause
                    : wr_hit ? reg_req_i.wdata[BIT_TX_EN] : tx_en_reg;
  assign manual_next = take_strap ? strap_i.manual_sel
                     : wr_hit ? reg_req_i.wdata[BIT_MANUAL] : manual_reg;

  // Duplex comes from negotiation when enabled, else from the duplex strap.
  assign half_now = strap_reg.an_en ? an_result_i.an_half_duplex : strap_reg.half_duplex;

  pause_resolve u_resolve (
    .manual_sel_i(manual_reg),
    .rx_en_i(rx_en_reg),
    .tx_en_i(tx_en_reg),
    .an_en_i(strap_reg.an_en),
    .half_i(half_now),
    .an_rx_i(an_result_i.an_rx_pause),
    .an_tx_i(an_result_i.an_tx_pause),
    .rx_act_o(rx_act_now),
    .tx_act_o(tx_act_now)
  );

  // Only local bits are held; nothing here reaches the PHY advertisement.
  assign reg_view = {25'h000_0000, bp_reg, half_reg, rx_act_reg, tx_act_reg,
                     rx_en_reg, tx_en_reg, manual_reg};
  assign rdata_next = hit ? reg_view : RDATA_RESET;

  // ----------------------------------------
  // Strap capture
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      strap_taken_reg <= 1'b0;
      strap_reg <= '0;
    end else if (clk_en_i) begin
      strap_taken_reg <= 1'b1;
      strap_reg <= strap_next;
    end
  end

  // ----------------------------------------
  // Control bits
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bp_reg <= 1'b0;
      rx_en_reg <= 1'b0;
      tx_en_reg <= 1'b0;
      manual_reg <= 1'b0;
    end else if (clk_en_i) begin
      bp_reg <= bp_next;
      rx_en_reg <= rx_en_next;
      tx_en_reg <= tx_en_next;
      manual_reg <= manual_next;
    end
  end

  // ----------------------------------------
  // Status bits
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      half_reg <= 1'b0;
      rx_act_reg <= 1'b0;
      tx_act_reg <= 1'b0;
    end else if (clk_en_i) begin
      half_reg <= half_now;
      rx_act_reg <= rx_act_now;
      tx_act_reg <= tx_act_now;
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_reg <= RDATA_RESET;
      rvalid_reg <= 1'b0;
    end else if (clk_en_i) begin
      rvalid_reg <= rd_req;
      if (rd_req) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  assign reg_rdata_o = rdata_reg;
  assign reg_rvalid_o = rvalid_reg;

  // ----------------------------------------
  // Outputs to the MAC
  // ----------------------------------------
  assign mac_flow_o.backpressure_en = bp_reg;
  assign mac_flow_o.half_duplex = half_reg;
  assign mac_flow_o.rx_pause_en = rx_act_reg;
  assign mac_flow_o.tx_pause_en = tx_act_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!nrst_i);

  a_bp_write_applied: assert property (
    clk_en_i && wr_hit && strap_taken_reg && !strap_load_i
    |=> mac_flow_o.backpressure_en == $past(reg_req_i.wdata[BIT_BP]))
    else $error("Backpressure enable did not follow the write.");

  a_duplex_read_back: assert property (
    clk_en_i && hit && !reg_req_i.wr
    |=> reg_rdata_o[BIT_DUP] == $past(half_reg))
    else $error("Duplex status bit read back wrong.");

  a_half_rx_off: assert property (
    clk_en_i && half_now |=> !mac_flow_o.rx_pause_en && !reg_view[BIT_RX_ACT])
    else $error("Receive pause active in half duplex.");

  a_half_tx_off: assert property (
    clk_en_i && half_now |=> !mac_flow_o.tx_pause_en && !reg_view[BIT_TX_ACT])
    else $error("Transmit pause active in half duplex.");

  a_manual_pause_bits: assert property (
    clk_en_i && (manual_reg || !strap_reg.an_en) && !half_now
    |=> mac_flow_o.tx_pause_en == $past(tx_en_reg)
        && mac_flow_o.rx_pause_en == $past(rx_en_reg))
    else $error("Manual pause bits not applied.");

  a_an_pause_result: assert property (
    clk_en_i && !manual_reg && strap_reg.an_en && !half_now
    |=> mac_flow_o.rx_pause_en == $past(an_result_i.an_rx_pause)
        && mac_flow_o.tx_pause_en == $past(an_result_i.an_tx_pause))
    else $error("Negotiated pause result not applied.");

  a_strap_first_take: assert property (
    clk_en_i && !strap_taken_reg
    |=> strap_taken_reg && bp_reg == $past(strap_i.backpressure)
        && manual_reg == $past(strap_i.manual_sel)
        && rx_en_reg == $past(strap_i.pause))
    else $error("Strap values not taken after reset.");

  a_strap_reload: assert property (
    clk_en_i && strap_load_i
    |=> tx_en_reg == $past(strap_i.pause) && bp_reg == $past(strap_i.backpressure)
        && manual_reg == $past(strap_i.manual_sel))
    else $error("Loader reload not applied.");

  a_reserved_zero: assert property (
    reg_rdata_o[DATA_W-1:BIT_BP+1] == '0)
    else $error("Reserved bits read nonzero.");

  a_unmapped_zero: assert property (
    clk_en_i && rd_req && !hit |=> reg_rdata_o == '0 && reg_rvalid_o)
    else $error("Unmapped read not zero.");

  a_freeze_hold: assert property (
    !clk_en_i |=> $stable(bp_reg) && $stable(manual_reg) && $stable(rdata_reg))
    else $error("State moved with clock enable low.");

  // ----------------------------------------
  // Write and strap checks
  // ----------------------------------------
  a_write_rx_en: assert property (
    clk_en_i && wr_hit && strap_taken_reg && !strap_load_i
    |=> rx_en_reg == $past(reg_req_i.wdata[BIT_RX_EN]))
    else $error("Receive pause enable did not follow the write.");

  a_write_tx_en: assert property (
    clk_en_i && wr_hit && strap_taken_reg && !strap_load_i
    |=> tx_en_reg == $past(reg_req_i.wdata[BIT_TX_EN]))
    else $error("Transmit pause enable did not follow the write.");

  a_write_manual_sel: assert property (
    clk_en_i && wr_hit && strap_taken_reg && !strap_load_i
    |=> manual_reg == $past(reg_req_i.wdata[BIT_MANUAL]))
    else $error("Manual select did not follow the write.");

  a_bp_half_duplex: assert property (
    clk_en_i && half_now && wr_hit && !take_strap
    |=> mac_flow_o.backpressure_en == $past(reg_req_i.wdata[BIT_BP])
        && !mac_flow_o.rx_pause_en && !mac_flow_o.tx_pause_en)
    else $error("Backpressure not applied alone in half duplex.");

  a_loader_beats_write: assert property (
    clk_en_i && strap_load_i && wr_hit
    |=> bp_reg == $past(strap_i.backpressure) && rx_en_reg == $past(strap_i.pause)
        && manual_reg == $past(strap_i.manual_sel))
    else $error("Write overrode a loader reload.");

  a_strap_pause_shared: assert property (
    clk_en_i && take_strap
    |=> rx_en_reg == tx_en_reg
        && tx_en_reg == $past(strap_i.pause))
    else $error("Pause enables not both taken from the pause strap.");

  a_other_write_ignored: assert property (
    clk_en_i && reg_req_i.sel && reg_req_i.wr && !hit && !take_strap
    |=> $stable(bp_reg) && $stable(rx_en_reg)
        && $stable(tx_en_reg) && $stable(manual_reg))
    else $error("Write to another address changed the register.");

  // ----------------------------------------
  // Read and duplex checks
  // ----------------------------------------
  a_read_valid_pulse: assert property (
    clk_en_i && rd_req |=> reg_rvalid_o)
    else $error("Read not answered with valid.");

  a_idle_no_valid: assert property (
    clk_en_i && !rd_req |=> !reg_rvalid_o)
    else $error("Valid raised without a read.");

  a_rdata_holds: assert property (
    clk_en_i && !rd_req |=> $stable(reg_rdata_o))
    else $error("Read data moved without a read.");

  a_rx_status_read: assert property (
    clk_en_i && hit && !reg_req_i.wr
    |=> reg_rdata_o[BIT_RX_ACT] == $past(rx_act_reg))
    else $error("Receive pause status read back wrong.");

  a_tx_status_read: assert property (
    clk_en_i && hit && !reg_req_i.wr
    |=> reg_rdata_o[BIT_TX_ACT] == $past(tx_act_reg))
    else $error("Transmit pause status read back wrong.");

  a_duplex_from_an: assert property (
    clk_en_i && strap_reg.an_en
    |=> mac_flow_o.half_duplex == $past(an_result_i.an_half_duplex))
    else $error("Duplex did not follow negotiation.");

  a_duplex_from_strap: assert property (
    clk_en_i && !strap_reg.an_en
    |=> mac_flow_o.half_duplex == $past(strap_reg.half_duplex))
    else $error("Duplex did not follow the duplex strap.");

  c_manual_write: cover property (clk_en_i && wr_hit && reg_req_i.wdata[BIT_MANUAL]);
  c_strap_reload: cover property (clk_en_i && strap_load_i && strap_taken_reg);
  c_half_duplex: cover property (clk_en_i && half_now && bp_reg);
  c_an_pause: cover property (clk_en_i && !manual_reg && strap_reg.an_en && rx_act_now);
  c_loader_beats_write: cover property (clk_en_i && strap_load_i && wr_hit);

endmodule // port_flow_control_select
`default_nettype wire

//--- verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import port_flow_ctrl_pkg::*;
  logic sys_clk_i;
  logic nrst_i;
  logic clk_en_i;
  reg_req_t reg_req_i;
  logic [DATA_W-1:0] reg_rdata_o;
  logic reg_rvalid_o;
  strap_t strap_i;
  logic strap_load_i;
  an_result_t an_result_i;
  mac_flow_t mac_flow_o;
  int failures;
  int n_checks;
  int cycles;
  int seed;
  logic [31:0] r;
  logic m_bp, m_rx, m_tx, m_man, m_an, m_half;

  port_flow_control_select u_port_flow_control_select (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .clk_en_i(clk_en_i),
    .reg_req_i(reg_req_i),
    .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o),
    .strap_i(strap_i),
    .strap_load_i(strap_load_i),
    .an_result_i(an_result_i),
    .mac_flow_o(mac_flow_o)
  );

  // ----------------------------------------
  // Clock and expectations
  // ----------------------------------------
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  function automatic logic [31:0] exp_view();
    logic dup, rxa, txa, own;
    dup = m_an ? an_result_i.an_half_duplex : m_half;
    own = m_man || !m_an;
    rxa = !dup && (own ? m_rx : an_result_i.an_rx_pause);
    txa = !dup && (own ? m_tx : an_result_i.an_tx_pause);
    return {25'h000_0000, m_bp, dup, rxa, txa, m_rx, m_tx, m_man};
  endfunction

  task automatic cmp_word(input string what, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic cmp_flag(input string what, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %b seen %b", what, e, g);
    end
  endtask

  // ----------------------------------------
  // Bus and strap tasks
  // ----------------------------------------
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    reg_req_i = '{sel: 1'b1, wr: 1'b0, addr: a, wdata: 32'h0000_0000};
    @(negedge sys_clk_i);
    reg_req_i.sel = 1'b0;
    cmp_flag("rvalid", 1'b1, reg_rvalid_o);
    cmp_word("rdata", e, reg_rdata_o);
    @(negedge sys_clk_i);
    cmp_flag("rvalid_drop", 1'b0, reg_rvalid_o);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    reg_req_i = '{sel: 1'b1, wr: 1'b1, addr: a, wdata: d};
    @(negedge sys_clk_i);
    reg_req_i.sel = 1'b0;
    if (a == PORT1_FLOW_CTRL_OFS) begin
      {m_bp, m_rx, m_tx, m_man} = {d[6], d[2:0]};
    end
    repeat (2) @(negedge sys_clk_i);
  endtask

  task automatic set_model(input strap_t s);
    {m_bp, m_rx, m_tx, m_man} = {s.backpressure, s.pause, s.pause, s.manual_sel};
    {m_an, m_half} = {s.an_en, s.half_duplex};
  endtask

  task automatic load(input strap_t s);
    strap_i = s;
    strap_load_i = 1'b1;
    @(negedge sys_clk_i);
    strap_load_i = 1'b0;
    set_model(s);
    repeat (2) @(negedge sys_clk_i);
  endtask

  task automatic do_reset(input strap_t s);
    nrst_i = 1'b0;
    strap_i = s;
    repeat (5) @(negedge sys_clk_i);
    cmp_word("mac_reset", 32'h0000_0000, {28'h000_0000, mac_flow_o});
    nrst_i = 1'b1;
    set_model(s);
    repeat (2) @(negedge sys_clk_i);
  endtask

  task automatic chk_all();
    logic [31:0] v;
    v = exp_view();
    cmp_word("mac_flow", {28'h000_0000, v[6:3]}, {28'h000_0000, mac_flow_o});
    rd(PORT1_FLOW_CTRL_OFS, v);
  endtask

  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      end_of_test();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    seed = 32'he39e_854d;
    failures = 0;
    n_checks = 0;
    cycles = 0;
    clk_en_i = 1'b1;
    reg_req_i = '0;
    strap_load_i = 1'b0;
    an_result_i = '0;
    r = $random(seed);
    do_reset(r[4:0]);
    chk_all();
    $display("Test reset done");
    for (int i = 0; i < 80; i++) begin
      r = $random(seed);
      an_result_i = r[7:5];
      strap_i = r[12:8];
      if (r[13] && r[14]) begin
        load(r[20:16]);
      end else begin
        wr(PORT1_FLOW_CTRL_OFS, $random(seed));
      end
      chk_all();
    end
    $display("Test random done");
    wr(PORT1_FLOW_CTRL_OFS, 32'hffff_ffff);
    chk_all();
    wr(12'h1a4, 32'h0000_0000);
    chk_all();
    rd(12'h1a4, 32'h0000_0000);
    $display("Test map done");
    r = $random(seed);
    strap_i = r[4:0];
    strap_load_i = 1'b1;
    reg_req_i = '{sel: 1'b1, wr: 1'b1, addr: PORT1_FLOW_CTRL_OFS,
                  wdata: {25'h000_0000, ~r[4], 3'b000, ~r[3], ~r[3], ~r[2]}};
    @(negedge sys_clk_i);
    strap_load_i = 1'b0;
    reg_req_i.sel = 1'b0;
    set_model(r[4:0]);
    repeat (2) @(negedge sys_clk_i);
    chk_all();
    $display("Test loader wins done");
    clk_en_i = 1'b0;
    reg_req_i = '{sel: 1'b1, wr: 1'b1, addr: PORT1_FLOW_CTRL_OFS, wdata: ~exp_view()};
    @(negedge sys_clk_i);
    reg_req_i.sel = 1'b0;
    clk_en_i = 1'b1;
    @(negedge sys_clk_i);
    chk_all();
    $display("Test freeze done");
    do_reset(~r[4:0]);
    chk_all();
    $display("Test second reset done");
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
